/* pmic_watchdog_supervisor.sv */
// Watchdog supervisor: refresh timer, expiry and event tallies, soft and hard reset sequencing.
// Assumes the power sequencer, regulators and register interface sit outside and share sys_clk.
`timescale 1ns/1ps
import pmic_wdog_pkg::*;
//
// Contract
// - Up-counting timer expires when count reaches the selected period.
// - Refresh-pending flag goes to 1 whenever a new count begins.
// - Host writes 1 to clear the flag; in-window clear restarts the timer.
// - Timer reset in off modes, held until host reset is released.
// - Period is two to the power of the code, in milliseconds.
// - Changing the period selection in system-on restarts the timer.
// - Initial period comes from the programmed default period.
// - Good refresh lowers expiry tally by 1; missed expiry raises it by 2.
// - Event starts when expiry tally equals the limit; limit default programmed.
// - Limit of 2 or less starts an event at the first expiry.
// - Single-ended mode accepts a clear anywhere in the period.
// - Windowed mode accepts only the second half; earlier is a failure.
// - Enable bit gates the timer; host changes it by secure write.
// - Enable default comes from the programmed enable setting.
// - Standby running needs standby-run enable; secure write when gated.
// - Soft reset keeps host reset released and reloads a subset.
// - Keep-config bit 1 preserves a regulator, 0 returns it to default.
// - Sequenced regulators return to default; unsequenced ones turn off.
// - After defaults reached wait 30 us, run, signal unmasked interrupt.
// - Hard reset powers down, waits 30 us, reloads all, powers up.
// - Event tally counts events; reaching the limit enters fault.
// - Event tally cleared whenever the device passes the off states.
// - Input events reset soft or hard by type bit; timer events hard.
module pmic_watchdog_supervisor #(
    parameter int MS_TICK_CYCLES = MS_CYCLES,
    parameter int NUM_SW = 7,
    parameter int NUM_LDO = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sys_on,
    input wire logic in_standby,
    input wire logic in_off,
    input wire logic host_reset_out_n,
    input wire logic otp_load,
    input wire logic [pmic_wdog_pkg::PERIOD_SEL_W-1:0] default_period_sel,
    input wire logic [pmic_wdog_pkg::EXPIRY_W-1:0] default_expiry_limit,
    input wire logic [pmic_wdog_pkg::EVENT_W-1:0] default_event_limit,
    input wire logic default_wdog_enable,
    input wire logic default_standby_run,
    input wire logic windowed_mode_sel,
    input wire logic secure_write_gate,
    input wire logic sw_secure_ok,
    input wire logic sw_period_wr,
    input wire logic [pmic_wdog_pkg::PERIOD_SEL_W-1:0] sw_period_data,
    input wire logic sw_enable_wr,
    input wire logic sw_enable_data,
    input wire logic sw_standby_wr,
    input wire logic sw_standby_data,
    input wire logic sw_expiry_limit_wr,
    input wire logic [pmic_wdog_pkg::EXPIRY_W-1:0] sw_expiry_limit_data,
    input wire logic sw_event_limit_wr,
    input wire logic [pmic_wdog_pkg::EVENT_W-1:0] sw_event_limit_data,
    input wire logic refresh_clear_wr,
    input wire logic event_tally_clear_wr,
    input wire logic irq_flag_clear_wr,
    input wire logic irq_mask,
    input wire logic ext_wdog_in,
    input wire logic ext_wdog_reset_type,
    input wire logic fail_link_n,
    input wire logic outputs_at_default,
    input wire logic pdn_done,
    input wire logic [NUM_SW-1:0] switcher_keep_config,
    input wire logic [NUM_SW-1:0] switcher_sequenced,
    input wire logic [NUM_LDO-1:0] linear_reg_keep_config,
    input wire logic [NUM_LDO-1:0] linear_reg_sequenced,
    output logic [pmic_wdog_pkg::PERIOD_SEL_W-1:0] wdog_period_sel,
    output logic wdog_enable_bit,
    output logic standby_run_enable,
    output logic [pmic_wdog_pkg::EXPIRY_W-1:0] expiry_limit,
    output logic [pmic_wdog_pkg::EVENT_W-1:0] event_limit,
    output logic refresh_pending_flag,
    output logic [pmic_wdog_pkg::EXPIRY_W-1:0] expiry_tally,
    output logic [pmic_wdog_pkg::EVENT_W-1:0] event_tally,
    output logic ext_wdog_irq_flag,
    output logic irq_out_n,
    output logic soft_reset_active,
    output logic hard_reset_active,
    output logic keep_host_released,
    output logic partial_reload,
    output logic full_reload,
    output logic power_up_req,
    output logic fault_req,
    output logic [NUM_SW-1:0] switcher_ramp_restore,
    output logic [NUM_SW-1:0] switcher_off,
    output logic [NUM_LDO-1:0] linear_reg_step_restore,
    output logic [NUM_LDO-1:0] linear_reg_off
);
    import pmic_wdog_pkg::*;

    initial begin
        if (NUM_SW < 1 || NUM_LDO < 1 || MS_TICK_CYCLES < 2) begin
            $error("Regulator counts must be at least 1 and tick at least 2 cycles");
        end
    end

    function automatic logic [PERIOD_MS_W-1:0] period_ms(input logic [PERIOD_SEL_W-1:0] sel);
        period_ms = PERIOD_MS_W'(1) << sel;
    endfunction

    function automatic logic sync_agree_low(input logic a, input logic b);
        sync_agree_low = !a && !b;
    endfunction

    wdog_state_e state_reg;
    logic [SETTLE_W-1:0] settle_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic armed_reg;
    logic counting_d_reg;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg;
    logic fail_s1_reg, fail_s2_reg, fail_s3_reg, fail_lvl_reg;
    logic tick;
    logic mode_ok, counting, refresh_req, win_ok, refresh_good, refresh_bad;
    logic expire, missed, restart, period_change, new_count;
    logic timer_event, ext_event, event_start, event_hard, fault_hit;
    logic irq_flag_next;
    logic [PERIOD_MS_W-1:0] period_now;
    logic [PERIOD_MS_W-1:0] count_plus;
    logic [EXPIRY_W:0] tally_up;
    logic [EVENT_W-1:0] event_next;

    // Pin inputs: three stages, a change is accepted once stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            ext_s3_reg <= 1'b1;
            ext_lvl_reg <= 1'b1;
            fail_s1_reg <= 1'b1;
            fail_s2_reg <= 1'b1;
            fail_s3_reg <= 1'b1;
            fail_lvl_reg <= 1'b1;
        end else begin
            ext_s1_reg <= ext_wdog_in;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_lvl_reg <= ext_s2_reg;
            end
            fail_s1_reg <= fail_link_n;
            fail_s2_reg <= fail_s1_reg;
            fail_s3_reg <= fail_s2_reg;
            if (fail_s2_reg == fail_s3_reg) begin
                fail_lvl_reg <= fail_s2_reg;
            end
        end
    end

    // Configuration; reloads override software writes in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdog_period_sel <= PERIOD_SEL_RST;
            wdog_enable_bit <= 1'b0;
            standby_run_enable <= 1'b0;
            expiry_limit <= EXPIRY_LIMIT_RST;
            event_limit <= EVENT_LIMIT_RST;
        end else if (otp_load || full_reload) begin
            wdog_period_sel <= default_period_sel;
            wdog_enable_bit <= default_wdog_enable;
            standby_run_enable <= default_standby_run;
            expiry_limit <= default_expiry_limit;
            event_limit <= default_event_limit;
        end else if (partial_reload) begin
            wdog_period_sel <= default_period_sel;
            wdog_enable_bit <= default_wdog_enable;
            standby_run_enable <= default_standby_run;
        end else begin
            if (sw_period_wr) begin
                wdog_period_sel <= sw_period_data;
            end
            if (sw_enable_wr && sw_secure_ok) begin
                wdog_enable_bit <= sw_enable_data;
            end
            if (sw_standby_wr && (!secure_write_gate || sw_secure_ok)) begin
                standby_run_enable <= sw_standby_data;
            end
            if (sw_expiry_limit_wr) begin
                expiry_limit <= sw_expiry_limit_data;
            end
            if (sw_event_limit_wr) begin
                event_limit <= sw_event_limit_data;
            end
        end
    end

    always_comb begin
        mode_ok = in_standby ? standby_run_enable : sys_on;
        counting = armed_reg && wdog_enable_bit && !in_off && mode_ok && (state_reg == ST_IDLE);
        period_now = period_ms(wdog_period_sel);
        count_plus = {1'b0, timer_reg} + PERIOD_MS_W'(1);
        // Reaching or passing, so a shorter period after a reload cannot be skipped
        expire = counting && tick && (count_plus >= period_now);
        refresh_req = counting && refresh_clear_wr;
        win_ok = !windowed_mode_sel || ({1'b0, timer_reg} >= (period_now >> 1));
        refresh_good = refresh_req && win_ok;
        refresh_bad = refresh_req && !win_ok;
        missed = (expire && !refresh_good) || refresh_bad;
        period_change = sw_period_wr && sys_on && (sw_period_data != wdog_period_sel);
        restart = refresh_good || missed || period_change;
        new_count = counting && (restart || !counting_d_reg);
        tally_up = {1'b0, expiry_tally} + {1'b0, EXPIRY_STEP_UP};
        if (expiry_limit <= EXPIRY_FIRST_LIMIT) begin
            timer_event = missed;
        end else begin
            timer_event = counting && (expiry_tally == expiry_limit);
        end
        ext_event = (state_reg == ST_IDLE) && !in_off && ext_lvl_reg
            && sync_agree_low(ext_s2_reg, ext_s3_reg);
        event_start = timer_event || ext_event;
        event_hard = timer_event || ext_wdog_reset_type;
        event_next = (event_tally == EVENT_MAX) ? EVENT_MAX : event_tally + EVENT_W'(1);
        fault_hit = event_start && (event_next == event_limit);
        irq_flag_next = (ext_wdog_irq_flag && !irq_flag_clear_wr) || (state_reg == ST_SOFT_DELAY
            && settle_reg == SETTLE_W'(SETTLE_CYCLES - 1));
    end

    wdog_ms_divider #(
        .TICK_CYCLES(MS_TICK_CYCLES)
    ) u_ms_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(counting),
        .clear(restart),
        .tick(tick)
    );

    // Timer stays stopped after off until the host reset is released again
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed_reg <= 1'b0;
            counting_d_reg <= 1'b0;
            timer_reg <= TIMER_RST;
        end else begin
            counting_d_reg <= counting;
            if (in_off) begin
                armed_reg <= 1'b0;
                timer_reg <= TIMER_RST;
            end else begin
                if (host_reset_out_n) begin
                    armed_reg <= 1'b1;
                end
                if (restart) begin
                    timer_reg <= TIMER_RST;
                end else if (counting && tick) begin
                    timer_reg <= count_plus[TIMER_W-1:0];
                end
            end
        end
    end

    // A new count sets the flag even if a clear lands in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            refresh_pending_flag <= 1'b0;
        end else if (new_count) begin
            refresh_pending_flag <= 1'b1;
        end else if (refresh_clear_wr || in_off) begin
            refresh_pending_flag <= 1'b0;
        end
    end

    // Tally cleared on event start so a single run of expiries fires once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            expiry_tally <= EXPIRY_RST;
        end else if (event_start) begin
            expiry_tally <= EXPIRY_RST;
        end else if (missed) begin
            expiry_tally <= tally_up[EXPIRY_W] ? EXPIRY_MAX : tally_up[EXPIRY_W-1:0];
        end else if (refresh_good && expiry_tally != EXPIRY_RST) begin
            expiry_tally <= expiry_tally - EXPIRY_W'(1);
        end
    end

    // Event increment wins over a host clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            event_tally <= EVENT_RST;
            fault_req <= 1'b0;
        end else begin
            fault_req <= fault_hit;
            if (in_off) begin
                event_tally <= EVENT_RST;
            end else if (event_start) begin
                event_tally <= event_next;
            end else if (event_tally_clear_wr) begin
                event_tally <= EVENT_RST;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ext_wdog_irq_flag <= 1'b0;
            irq_out_n <= 1'b1;
        end else begin
            ext_wdog_irq_flag <= irq_flag_next;
            irq_out_n <= !(irq_flag_next && !irq_mask);
        end
    end

    // Reset sequencing; a fault hit leaves the sequencer to take over
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            settle_reg <= SETTLE_RST;
            soft_reset_active <= 1'b0;
            hard_reset_active <= 1'b0;
            keep_host_released <= 1'b0;
            partial_reload <= 1'b0;
            full_reload <= 1'b0;
            power_up_req <= 1'b0;
            switcher_ramp_restore <= '0;
            switcher_off <= '0;
            linear_reg_step_restore <= '0;
            linear_reg_off <= '0;
        end else begin
            partial_reload <= 1'b0;
            full_reload <= 1'b0;
            power_up_req <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    settle_reg <= SETTLE_RST;
                    if (event_start && !fault_hit) begin
                        if (event_hard) begin
                            state_reg <= ST_HARD_PDN;
                            hard_reset_active <= 1'b1;
                        end else begin
                            state_reg <= ST_SOFT_WAIT;
                            soft_reset_active <= 1'b1;
                            keep_host_released <= 1'b1;
                            partial_reload <= 1'b1;
                            switcher_ramp_restore <= switcher_sequenced & ~switcher_keep_config;
                            switcher_off <= ~switcher_sequenced & ~switcher_keep_config;
                            linear_reg_step_restore <= linear_reg_sequenced & ~linear_reg_keep_config;
                            linear_reg_off <= ~linear_reg_sequenced & ~linear_reg_keep_config;
                        end
                    end
                end
                ST_SOFT_WAIT: begin
                    if (outputs_at_default) begin
                        state_reg <= ST_SOFT_DELAY;
                    end
                end
                ST_SOFT_DELAY: begin
                    if (settle_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                        state_reg <= ST_IDLE;
                        soft_reset_active <= 1'b0;
                        keep_host_released <= 1'b0;
                        switcher_ramp_restore <= '0;
                        switcher_off <= '0;
                        linear_reg_step_restore <= '0;
                        linear_reg_off <= '0;
                    end else begin
                        settle_reg <= settle_reg + SETTLE_W'(1);
                    end
                end
                ST_HARD_PDN: begin
                    if (pdn_done) begin
                        state_reg <= ST_HARD_DELAY;
                    end
                end
                ST_HARD_DELAY: begin
                    if (settle_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                        state_reg <= ST_HARD_HOLD;
                        full_reload <= 1'b1;
                    end else begin
                        settle_reg <= settle_reg + SETTLE_W'(1);
                    end
                end
                ST_HARD_HOLD: begin
                    // Power-up held off while the fail line is pulled low outside
                    if (fail_lvl_reg) begin
                        state_reg <= ST_IDLE;
                        hard_reset_active <= 1'b0;
                        power_up_req <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    soft_reset_active <= 1'b0;
                    hard_reset_active <= 1'b0;
                    keep_host_released <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* pmic_watchdog_supervisor_bench.sv */
// Self-checking bench for the watchdog supervisor.
// Assumes a shortened millisecond tick and the host model for refreshes.
`timescale 1ns/1ps
module pmic_watchdog_supervisor_bench;
    import pmic_wdog_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, sys_on = 1'b1, in_standby = 1'b0, in_off = 1'b0, otp_load = 1'b0;
    logic host_reset_out_n = 1'b1, default_wdog_enable = 1'b1, default_standby_run = 1'b0, windowed_mode_sel = 1'b0;
    logic [3:0] default_period_sel = 4'h1, default_event_limit = 4'hf, sw_period_data = 4'h3;
    logic [2:0] default_expiry_limit = 3'h7, sw_expiry_limit_data = 3'h2, expiry_limit, expiry_tally, t;
    logic secure_write_gate = 1'b1, sw_secure_ok = 1'b0, sw_period_wr = 1'b0, sw_enable_wr = 1'b0;
    logic sw_enable_data = 1'b0, sw_standby_wr = 1'b0, sw_standby_data = 1'b0, sw_expiry_limit_wr = 1'b0;
    logic sw_event_limit_wr = 1'b0, event_tally_clear_wr = 1'b0, irq_flag_clear_wr = 1'b0, irq_mask = 1'b0;
    logic ext_wdog_in = 1'b1, ext_wdog_reset_type = 1'b0, fail_link_n = 1'b1, outputs_at_default = 1'b0;
    logic [6:0] switcher_keep_config = 7'h55, switcher_sequenced = 7'h0f, switcher_ramp_restore, switcher_off;
    logic [3:0] linear_reg_keep_config = 4'h3, linear_reg_sequenced = 4'h5, linear_reg_step_restore, linear_reg_off;
    logic [3:0] wdog_period_sel, event_limit, event_tally, sw_event_limit_data = 4'h0;
    logic wdog_enable_bit, standby_run_enable, refresh_pending_flag, ext_wdog_irq_flag, irq_out_n, fault_req;
    logic soft_reset_active, hard_reset_active, keep_host_released, partial_reload, full_reload, power_up_req;
    logic refresh_clear_wr, pdn_done = 1'b0, auto_on = 1'b0, kick = 1'b0;
    int miscompares = 0, total_checks = 0, n;
    pmic_watchdog_supervisor #(.MS_TICK_CYCLES(4)) uut (.*);
    wd_host_model host (.sys_clk, .auto_on, .kick, .refresh_pending_flag, .refresh_clear_wr);
    always #20 sys_clk = ~sys_clk;
    task cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function logic cnd(input int k);
        case (k)
            0: return refresh_pending_flag;
            1: return expiry_tally != 3'h0;
            2: return hard_reset_active;
            3: return full_reload;
            4: return soft_reset_active;
            5: return !irq_out_n;
            default: return power_up_req;
        endcase
    endfunction
    // Counts cycles until the condition holds; a spent bound ends the run
    task wt(input int k, input int lim);
        for (n = 0; n < lim && cnd(k) !== 1'b1; n++) cyc(1);
        if (cnd(k) !== 1'b1) begin
            chk(1'b0, "timeout");
            final_report;
        end
    endtask
    task rf;
        kick = 1'b1;
        cyc(1);
        kick = 1'b0;
        cyc(3);
    endtask
    task t_timer;
        wt(0, 20);
        wt(1, 40);
        chk(n >= 5 && n <= 11, "period");
        chk(expiry_tally === 3'h2, "miss step");
        rf;
        chk(expiry_tally === 3'h1 && refresh_pending_flag === 1'b1, "refresh");
        windowed_mode_sel = 1'b1;
        sw_period_wr = 1'b1;
        cyc(1);
        sw_period_wr = 1'b0;
        chk(wdog_period_sel === 4'h3, "period write");
        rf;
        chk(expiry_tally === 3'h3, "early refresh");
        windowed_mode_sel = 1'b0;
        $display("t_timer done");
    endtask
    task t_hold;
        in_standby = 1'b1;
        sys_on = 1'b0;
        t = expiry_tally;
        cyc(70);
        chk(expiry_tally === t, "standby hold");
        in_standby = 1'b0;
        sys_on = 1'b1;
        sw_enable_wr = 1'b1;
        cyc(1);
        chk(wdog_enable_bit === 1'b1, "unsecured write");
        sw_secure_ok = 1'b1;
        cyc(1);
        chk(wdog_enable_bit === 1'b0, "secure write");
        t = expiry_tally;
        cyc(70);
        chk(expiry_tally === t, "disabled hold");
        sw_enable_data = 1'b1;
        cyc(1);
        sw_enable_wr = 1'b0;
        sw_secure_ok = 1'b0;
        auto_on = 1'b1;
        $display("t_hold done");
    endtask
    task t_soft;
        ext_wdog_in = 1'b0;
        wt(4, 10);
        chk(keep_host_released === 1'b1 && partial_reload === 1'b1, "soft start");
        chk({switcher_ramp_restore, switcher_off, linear_reg_step_restore, linear_reg_off} === 22'h05_2048, "masks");
        outputs_at_default = 1'b1;
        wt(5, 900);
        chk(n >= 749 && soft_reset_active === 1'b0 && ext_wdog_irq_flag === 1'b1, "soft end");
        chk(event_tally === 4'h1, "event count");
        ext_wdog_in = 1'b1;
        outputs_at_default = 1'b0;
        irq_flag_clear_wr = 1'b1;
        event_tally_clear_wr = 1'b1;
        cyc(1);
        irq_flag_clear_wr = 1'b0;
        event_tally_clear_wr = 1'b0;
        chk(event_tally === 4'h0 && irq_out_n === 1'b1, "host clears");
        $display("t_soft done");
    endtask
    task t_hard;
        auto_on = 1'b0;
        default_period_sel = 4'h2;
        sw_expiry_limit_wr = 1'b1;
        cyc(1);
        sw_expiry_limit_wr = 1'b0;
        wt(2, 100);
        chk(event_tally === 4'h1 && soft_reset_active === 1'b0, "timer event");
        fail_link_n = 1'b0;
        pdn_done = 1'b1;
        wt(3, 900);
        chk(n >= 749, "hard settle");
        cyc(1);
        chk(wdog_period_sel === 4'h2, "full reload");
        cyc(20);
        chk(hard_reset_active === 1'b1, "fail held");
        fail_link_n = 1'b1;
        wt(6, 20);
        pdn_done = 1'b0;
        auto_on = 1'b1;
        $display("t_hard done");
    endtask
    task t_off;
        in_off = 1'b1;
        sys_on = 1'b0;
        cyc(2);
        chk(event_tally === 4'h0, "off clear");
        auto_on = 1'b0;
        host_reset_out_n = 1'b0;
        in_off = 1'b0;
        sys_on = 1'b1;
        cyc(40);
        chk(expiry_tally === 3'h0, "held in reset");
        host_reset_out_n = 1'b1;
        wt(1, 40);
        $display("t_off done");
    endtask
    initial begin
        cyc(5);
        rstn = 1'b1;
        otp_load = 1'b1;
        cyc(1);
        otp_load = 1'b0;
        t_timer;
        t_hold;
        t_soft;
        t_hard;
        t_off;
        final_report;
    end
endmodule

/* pmic_wdog_pkg.sv */
// Constants, reset values and state codes for the watchdog supervisor.
// Assumes a single 25 MHz system clock.
package pmic_wdog_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int SETTLE_US = 30;
    localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 10;

    localparam int PERIOD_SEL_W = 4;
    localparam int PERIOD_MS_W = 17;
    localparam int TIMER_W = 16;
    localparam int EXPIRY_W = 3;
    localparam int EVENT_W = 4;

    localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [EXPIRY_W-1:0] EXPIRY_RST = 3'h0;
    localparam logic [EXPIRY_W-1:0] EXPIRY_MAX = 3'h7;
    localparam logic [EXPIRY_W-1:0] EXPIRY_STEP_UP = 3'h2;
    localparam logic [EXPIRY_W-1:0] EXPIRY_FIRST_LIMIT = 3'h2;
    localparam logic [EVENT_W-1:0] EVENT_RST = 4'h0;
    localparam logic [EVENT_W-1:0] EVENT_MAX = 4'hf;
    localparam logic [PERIOD_SEL_W-1:0] PERIOD_SEL_RST = 4'h0;
    localparam logic [EXPIRY_W-1:0] EXPIRY_LIMIT_RST = 3'h0;
    localparam logic [EVENT_W-1:0] EVENT_LIMIT_RST = 4'h0;
    localparam logic [SETTLE_W-1:0] SETTLE_RST = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_SOFT_WAIT  = 3'b001,
        ST_SOFT_DELAY = 3'b010,
        ST_HARD_PDN   = 3'b011,
        ST_HARD_DELAY = 3'b100,
        ST_HARD_HOLD  = 3'b101
    } wdog_state_e;

endpackage

/* wd_host_model.sv */
// Host side: refreshes by writing one to the pending flag.
// Assumes the bench asks for single refreshes or steady servicing.
`timescale 1ns/1ps
module wd_host_model (
    input wire logic sys_clk,
    input wire logic auto_on,
    input wire logic kick,
    input wire logic refresh_pending_flag,
    output logic refresh_clear_wr = 1'b0
);
    // Every other cycle, so each clear is a separate write
    always @(posedge sys_clk) begin
        refresh_clear_wr <= kick | (auto_on & refresh_pending_flag & !refresh_clear_wr);
    end
endmodule

/* wd_sup_props.sv */
// Port-level checks for the watchdog supervisor.
// Assumes one clock domain with async active-low reset.
`timescale 1ns/1ps
module wd_sup_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_off,
    input wire logic irq_mask,
    input wire logic wdog_enable_bit,
    input wire logic [pmic_wdog_pkg::EXPIRY_W-1:0] expiry_tally,
    input wire logic [pmic_wdog_pkg::EVENT_W-1:0] event_tally,
    input wire logic soft_reset_active,
    input wire logic keep_host_released,
    input wire logic hard_reset_active,
    input wire logic full_reload,
    input wire logic irq_out_n
);
    import pmic_wdog_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_tally_rise: assert property (expiry_tally > $past(expiry_tally) |->
        expiry_tally == $past(expiry_tally) + 3'h2 || expiry_tally == 3'h7) else $error("tally rise");
    a_tally_fall: assert property (expiry_tally < $past(expiry_tally) |->
        expiry_tally == $past(expiry_tally) - 3'h1 || expiry_tally == 3'h0) else $error("tally fall");
    a_disabled_hold: assert property (!wdog_enable_bit && !$past(wdog_enable_bit) |->
        $stable(expiry_tally) || expiry_tally == 3'h0) else $error("disabled tally moved");
    a_soft_host: assert property (soft_reset_active |-> keep_host_released) else $error("host reset");
    a_event_step: assert property (event_tally != $past(event_tally) |->
        event_tally == $past(event_tally) + 4'h1 || event_tally == 4'h0) else $error("event step");
    a_off_clear: assert property (in_off |=> event_tally == 4'h0) else $error("off clear");
    a_reload_hard: assert property (full_reload |-> hard_reset_active) else $error("reload");
    a_irq_cause: assert property ($fell(irq_out_n) |->
        !irq_mask && $past(soft_reset_active)) else $error("irq cause");
endmodule
bind pmic_watchdog_supervisor wd_sup_chk chk (.sys_clk, .rstn, .in_off, .irq_mask, .wdog_enable_bit, .expiry_tally,
    .event_tally, .soft_reset_active, .keep_host_released, .hard_reset_active, .full_reload, .irq_out_n);

/* wdog_ms_divider.sv */
// Millisecond enable divider for the watchdog timer.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
module wdog_ms_divider #(
    parameter int TICK_CYCLES = 25000
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic clear,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] div_reg;

    initial begin
        if (TICK_CYCLES < 2) begin
            $error("TICK_CYCLES must be at least 2");
        end
    end

    // Clear restarts the partial millisecond so a restart gives a full period
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else if (clear || !run) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else if (div_reg == LAST) begin
            div_reg <= '0;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + CW'(1);
            tick <= 1'b0;
        end
    end
endmodule
